/* File: pkg/lcr_pkg.sv */
// ****************************************************************
// Lane 0 conditioning register constants
// ****************************************************************
package lcr_pkg;

	// Byte addresses of the lane 0 registers
	localparam logic [7:0] ADDR_BOOST_A0  = 8'h0f;
	localparam logic [7:0] ADDR_THRESH_A0 = 8'h12;
	localparam logic [7:0] ADDR_MUTE_SEL0 = 8'h15;
	localparam logic [7:0] ADDR_BOOST_B0  = 8'h16;
	localparam logic [7:0] ADDR_SWING1_0  = 8'h17;
	localparam logic [7:0] ADDR_SWING2_0  = 8'h18;
	localparam logic [7:0] ADDR_THRESH_B0 = 8'h19;

	// Reset values
	localparam logic [7:0] RST_BOOST  = 8'h20;
	localparam logic [7:0] RST_THRESH = 8'h00;
	localparam logic [7:0] RST_MUTE   = 8'h00;
	localparam logic [7:0] RST_SWING1 = 8'h03;
	localparam logic [7:0] RST_SWING2 = 8'h03;

	// Value read back from an unmapped address
	localparam logic [7:0] RD_UNMAPPED = 8'h00;

	// Field positions
	localparam int BOOST_EN_BIT   = 5;
	localparam int BOOST_GAIN_LSB = 3;
	localparam int BOOST_LVL_LSB  = 0;
	localparam int THR_DEASS_LSB  = 2;
	localparam int THR_ASS_LSB    = 0;
	localparam int MUTE_AUTO_BIT  = 5;
	localparam int MUTE_MAN_BIT   = 4;
	localparam int SWING1_MSB     = 6;

	// Input detector synchroniser depth
	localparam int SYNC_STAGES = 3;

	// Boost filter setting for one input
	typedef struct packed {
		logic       en;
		logic [1:0] gain_stage_sel;
		logic [2:0] boost_level_sel;
	} lcr_boost_t;

	// Quiet detect thresholds for one input
	typedef struct packed {
		logic [1:0] deassert_sel;
		logic [1:0] assert_sel;
	} lcr_thresh_t;

	// Full lane 0 register image
	typedef struct packed {
		logic [7:0] boost_ctrl_in_a0;
		logic [7:0] quiet_thresh_in_a0;
		logic [7:0] quiet_mute_sel_out0;
		logic [7:0] boost_ctrl_in_b0;
		logic [7:0] swing_ctrl1_out0;
		logic [7:0] swing_ctrl2_out0;
		logic [7:0] quiet_thresh_in_b0;
	} lcr_regs_t;

	localparam lcr_regs_t RST_REGS = '{
		boost_ctrl_in_a0:    RST_BOOST,
		quiet_thresh_in_a0:  RST_THRESH,
		quiet_mute_sel_out0: RST_MUTE,
		boost_ctrl_in_b0:    RST_BOOST,
		swing_ctrl1_out0:    RST_SWING1,
		swing_ctrl2_out0:    RST_SWING2,
		quiet_thresh_in_b0:  RST_THRESH
	};

endpackage

/* File: logic/lcr_sig_sync.sv */
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Signal present synchroniser for one input detector
// ****************************************************************
module lcr_sig_sync
(
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic rst_b,
	// Raw comparator result from the analog detector
	input  wire logic present_raw,
	// Filtered signal present level
	output var  logic present_q
);

	logic [lcr_pkg::SYNC_STAGES-1:0] sync_q;
	logic [lcr_pkg::SYNC_STAGES-1:0] sync_d;
	logic                            present_d;

	// Shift chain; the first stage feeds only the second
	always_comb
	begin
		sync_d    = {sync_q[lcr_pkg::SYNC_STAGES-2:0], present_raw};
		present_d = present_q;
		// Accept a change only once stages two and three agree
		if (sync_q[1] == sync_q[2])
			present_d = sync_q[2];
	end

	// Register stage
	always_ff @(posedge clk_sys)
	begin
		if (!rst_b)
		begin
			sync_q    <= '0;
			present_q <= 1'b0;
		end
		else
		begin
			sync_q    <= sync_d;
			present_q <= present_d;
		end
	end

endmodule
`default_nettype wire

/* File: logic/lcr_lane0_regs.sv */
`timescale 1ns/1ps
`default_nettype none

// Function
// - Each boost control register carries enable in bit 5, gain stage in 4:3, level in 2:0.
// - The boost field resets to 20 hex, enable alone, which means filter bypass.
// - Host boost codes 2A to 3D hex pass unchanged to the filter.
// - Input A and input B boost registers sit at their own addresses and act alone.
// - Threshold registers hold de-assert select in 3:2 and assert select in 1:0.
// - Threshold code 00 is the default lowest pair, higher codes step both levels up.
// - With the auto bit set the output mutes by itself, else manual bit 4 decides.
// - Manual bit 0 keeps the output on with detection off, 1 holds it muted.
// - The seven-bit first swing field resets to 03 hex, 07 hex gives higher swing.
// - The eight-bit second swing field resets to 03 hex and the host sets it to 01 hex.
// - A soft reset returns every register here to its default.
// - The host reaches registers by byte address with one data byte per access.

// ****************************************************************
// Lane 0 conditioning register slice
// ****************************************************************
module lcr_lane0_regs
(
	// Clock and reset
	input  wire logic               clk_sys,
	input  wire logic               rst_b,
	// Byte register access from the serial slave engine
	input  wire logic [7:0]         reg_addr,
	input  wire logic [7:0]         reg_wdata,
	input  wire logic               reg_wr,
	input  wire logic               reg_rd,
	input  wire logic               soft_rst,
	output var  logic [7:0]         rd_data_q,
	output var  logic               rd_valid_q,
	// Lane routing and raw detector results
	input  wire logic               sel_in_a,
	input  wire logic [1:0]         present_raw,
	// Analog control fields
	output var  lcr_pkg::lcr_boost_t  boost_a_q,
	output var  lcr_pkg::lcr_boost_t  boost_b_q,
	output var  lcr_pkg::lcr_thresh_t thresh_a_q,
	output var  lcr_pkg::lcr_thresh_t thresh_b_q,
	output var  logic [6:0]         swing1_q,
	output var  logic [7:0]         swing2_q,
	// Output driver control
	output var  logic               out0_mute_q,
	output var  logic               detect_en_q
);

	lcr_pkg::lcr_regs_t regs_q;
	lcr_pkg::lcr_regs_t regs_d;
	logic [7:0]         rd_data_d;
	logic               rd_valid_d;
	logic               mute_d;
	logic               detect_en_d;
	logic [1:0]         present;
	logic               present_sel;

	// ****************************************************************
	// Input detectors
	// ****************************************************************

	// One synchroniser per input, the raw results come from another domain
	generate
		for (genvar i = 0; i < 2; i++)
		begin : g_det
			lcr_sig_sync u_sync
			(
				.clk_sys     (clk_sys),
				.rst_b       (rst_b),
				.present_raw (present_raw[i]),
				.present_q   (present[i])
			);
		end
	endgenerate

	assign present_sel = sel_in_a ? present[0] : present[1];

	// ****************************************************************
	// Register file
	// ****************************************************************

	// Write decode; soft reset beats a write in the same cycle
	always_comb
	begin
		regs_d = regs_q;
		if (soft_rst)
			regs_d = lcr_pkg::RST_REGS;
		else if (reg_wr)
		begin
			// Whole byte is kept, reserved bits included
			case (reg_addr)
				lcr_pkg::ADDR_BOOST_A0:  regs_d.boost_ctrl_in_a0    = reg_wdata;
				lcr_pkg::ADDR_THRESH_A0: regs_d.quiet_thresh_in_a0  = reg_wdata;
				lcr_pkg::ADDR_MUTE_SEL0: regs_d.quiet_mute_sel_out0 = reg_wdata;
				lcr_pkg::ADDR_BOOST_B0:  regs_d.boost_ctrl_in_b0    = reg_wdata;
				lcr_pkg::ADDR_SWING1_0:  regs_d.swing_ctrl1_out0    = reg_wdata;
				lcr_pkg::ADDR_SWING2_0:  regs_d.swing_ctrl2_out0    = reg_wdata;
				lcr_pkg::ADDR_THRESH_B0: regs_d.quiet_thresh_in_b0  = reg_wdata;
				default:                 regs_d = regs_q;
			endcase
		end
	end

	// Read mux, answered one cycle after the strobe
	always_comb
	begin
		rd_valid_d = reg_rd;
		rd_data_d  = lcr_pkg::RD_UNMAPPED;
		case (reg_addr)
			lcr_pkg::ADDR_BOOST_A0:  rd_data_d = regs_q.boost_ctrl_in_a0;
			lcr_pkg::ADDR_THRESH_A0: rd_data_d = regs_q.quiet_thresh_in_a0;
			lcr_pkg::ADDR_MUTE_SEL0: rd_data_d = regs_q.quiet_mute_sel_out0;
			lcr_pkg::ADDR_BOOST_B0:  rd_data_d = regs_q.boost_ctrl_in_b0;
			lcr_pkg::ADDR_SWING1_0:  rd_data_d = regs_q.swing_ctrl1_out0;
			lcr_pkg::ADDR_SWING2_0:  rd_data_d = regs_q.swing_ctrl2_out0;
			lcr_pkg::ADDR_THRESH_B0: rd_data_d = regs_q.quiet_thresh_in_b0;
			default:                 rd_data_d = lcr_pkg::RD_UNMAPPED;
		endcase
		if (!reg_rd)
			rd_data_d = rd_data_q; // Hold last answer between reads
	end

	// Mute choice: detector in auto mode, manual bit otherwise
	always_comb
	begin
		if (regs_q.quiet_mute_sel_out0[lcr_pkg::MUTE_AUTO_BIT])
		begin
			mute_d      = ~present_sel;
			detect_en_d = 1'b1;
		end
		else
		begin
			mute_d      = regs_q.quiet_mute_sel_out0[lcr_pkg::MUTE_MAN_BIT];
			detect_en_d = 1'b0;
		end
	end

	// Register stage
	always_ff @(posedge clk_sys)
	begin
		if (!rst_b)
		begin
			regs_q      <= lcr_pkg::RST_REGS;
			rd_data_q   <= lcr_pkg::RD_UNMAPPED;
			rd_valid_q  <= 1'b0;
			out0_mute_q <= 1'b0;
			detect_en_q <= 1'b0;
		end
		else
		begin
			regs_q      <= regs_d;
			rd_data_q   <= rd_data_d;
			rd_valid_q  <= rd_valid_d;
			out0_mute_q <= mute_d;
			detect_en_q <= detect_en_d;
		end
	end

	// ****************************************************************
	// Field outputs, taken straight from the stored bytes
	// ****************************************************************

	// Codes pass through untouched; the analog side decodes them
	assign boost_a_q  = regs_q.boost_ctrl_in_a0[lcr_pkg::BOOST_EN_BIT:0];
	assign boost_b_q  = regs_q.boost_ctrl_in_b0[lcr_pkg::BOOST_EN_BIT:0];
	assign thresh_a_q = regs_q.quiet_thresh_in_a0[3:0];
	assign thresh_b_q = regs_q.quiet_thresh_in_b0[3:0];
	assign swing1_q   = regs_q.swing_ctrl1_out0[lcr_pkg::SWING1_MSB:0];
	assign swing2_q   = regs_q.swing_ctrl2_out0;

	// ****************************************************************
	// Checks
	// ****************************************************************

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	boost_field_map_a: assert property (
		reg_wr && !soft_rst && reg_addr == lcr_pkg::ADDR_BOOST_A0 |=>
		boost_a_q.en == $past(reg_wdata[5]) &&
		boost_a_q.gain_stage_sel == $past(reg_wdata[4:3]) &&
		boost_a_q.boost_level_sel == $past(reg_wdata[2:0]))
		else $error("Boost A fields do not match written byte");

	boost_bypass_rst_a: assert property (
		soft_rst |=> boost_a_q == 6'h20 && boost_b_q == 6'h20)
		else $error("Boost fields not at bypass after soft reset");

	boost_code_pass_a: assert property (
		reg_wr && !soft_rst && reg_addr == lcr_pkg::ADDR_BOOST_B0 ##1
		(!reg_wr && !soft_rst) [*2] |->
		boost_b_q == $past(reg_wdata[5:0], 2))
		else $error("Boost B code changed on its way to the filter");

	boost_indep_a: assert property (
		reg_wr && !soft_rst && reg_addr == lcr_pkg::ADDR_BOOST_A0 |=> $stable(boost_b_q))
		else $error("Write to input A boost disturbed input B");

	thresh_field_map_a: assert property (
		reg_wr && !soft_rst && reg_addr == lcr_pkg::ADDR_THRESH_B0 |=>
		thresh_b_q.deassert_sel == $past(reg_wdata[3:2]) &&
		thresh_b_q.assert_sel == $past(reg_wdata[1:0]))
		else $error("Threshold B fields do not match written byte");

	thresh_default_a: assert property (
		soft_rst |=> thresh_a_q == 4'h0 && thresh_b_q == 4'h0)
		else $error("Thresholds not at lowest code after soft reset");

	auto_mute_a: assert property (
		regs_q.quiet_mute_sel_out0[5] && $stable(regs_q) && $stable(present_sel) |=>
		out0_mute_q == !$past(present_sel) && detect_en_q)
		else $error("Auto mode mute does not follow detector");

	manual_mute_a: assert property (
		!regs_q.quiet_mute_sel_out0[5] |=>
		out0_mute_q == $past(regs_q.quiet_mute_sel_out0[4]) && !detect_en_q)
		else $error("Manual mute bit not obeyed");

	swing_default_a: assert property (
		soft_rst |=> swing1_q == 7'h03 && swing2_q == 8'h03)
		else $error("Swing fields not at default after soft reset");

	read_back_a: assert property (
		reg_wr && !soft_rst && reg_addr == lcr_pkg::ADDR_SWING2_0 ##1
		reg_rd && !reg_wr && !soft_rst && reg_addr == lcr_pkg::ADDR_SWING2_0 |=>
		rd_valid_q && rd_data_q == $past(reg_wdata, 2))
		else $error("Read back differs from the byte written");

	reserved_keep_a: assert property (
		reg_wr && !soft_rst && reg_addr == lcr_pkg::ADDR_MUTE_SEL0 |=>
		regs_q.quiet_mute_sel_out0 == $past(reg_wdata))
		else $error("Reserved bits not stored");

	sel_follow_a: assert property (
		regs_q.quiet_mute_sel_out0[5] && sel_in_a && $stable(regs_q) |=>
		out0_mute_q == !$past(present[0]))
		else $error("Auto mute ignores selected input A");

	cover_soft_rst_c: cover property (soft_rst ##1 boost_a_q == 6'h20);
	cover_auto_mute_c: cover property (regs_q.quiet_mute_sel_out0[5] ##1 out0_mute_q);
	cover_read_c: cover property (reg_rd ##1 rd_valid_q);
	cover_swing_hi_c: cover property (swing1_q == 7'h07 && swing2_q == 8'h01);

endmodule
`default_nettype wire

/* File: test/lcr_lane0_regs_tb.sv */
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Lane 0 conditioning register slice bench
// ****************************************************************
module testbench;
	logic                 clk_sys     = 1'b0;
	logic                 rst_b       = 1'b0;
	logic [7:0]           reg_addr    = 8'h00;
	logic [7:0]           reg_wdata   = 8'h00;
	logic                 reg_wr      = 1'b0;
	logic                 reg_rd      = 1'b0;
	logic                 soft_rst    = 1'b0;
	logic                 sel_in_a    = 1'b1;
	logic [1:0]           present_raw = 2'b00;
	logic [7:0]           rd_data_q;
	logic                 rd_valid_q;
	lcr_pkg::lcr_boost_t  boost_a_q;
	lcr_pkg::lcr_boost_t  boost_b_q;
	lcr_pkg::lcr_thresh_t thresh_a_q;
	lcr_pkg::lcr_thresh_t thresh_b_q;
	logic [6:0]           swing1_q;
	logic [7:0]           swing2_q;
	logic                 out0_mute_q;
	logic                 detect_en_q;
	logic [7:0]           mdl [logic [7:0]];
	logic [31:0]          seed = 32'h4378;
	int                   error_cnt = 0;
	int                   tests_run = 0;
	logic [7:0] addrs [7] = '{8'h0f, 8'h12, 8'h15, 8'h16, 8'h17, 8'h18, 8'h19};
	logic [7:0] dflt  [7] = '{8'h20, 8'h00, 8'h00, 8'h20, 8'h03, 8'h03, 8'h00};
	// Host keeps reserved bits at zero, so random data is masked per register
	logic [7:0] wmask [7] = '{8'h3f, 8'h0f, 8'h30, 8'h3f, 8'h7f, 8'hff, 8'h0f};
	logic [7:0] codes [9] = '{8'h20, 8'h2a, 8'h30, 8'h32, 8'h35, 8'h37, 8'h39, 8'h3b, 8'h3d};

	// 200 MHz clock
	always #2.5 clk_sys = ~clk_sys;

	lcr_lane0_regs DUT (.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .soft_rst(soft_rst),
		.rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q), .sel_in_a(sel_in_a),
		.present_raw(present_raw), .boost_a_q(boost_a_q), .boost_b_q(boost_b_q),
		.thresh_a_q(thresh_a_q), .thresh_b_q(thresh_b_q), .swing1_q(swing1_q),
		.swing2_q(swing2_q), .out0_mute_q(out0_mute_q), .detect_en_q(detect_en_q));

	// Pseudo random source, fixed start
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic model_reset();
		foreach (addrs[i]) mdl[addrs[i]] = dflt[i];
	endtask

	// One byte write, strobe held for exactly one taking edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		#1 reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(posedge clk_sys);
		#1 reg_wr = 1'b0;
		if (mdl.exists(a)) mdl[a] = d;
	endtask

	// One byte read, answer checked in the cycle after the taking edge
	task automatic rd(input logic [7:0] a);
		@(posedge clk_sys);
		#1 reg_addr = a;
		reg_rd = 1'b1;
		@(posedge clk_sys);
		#1 reg_rd = 1'b0;
		chk({7'h00, rd_valid_q}, 8'h01);
		chk(rd_data_q, mdl.exists(a) ? mdl[a] : 8'h00);
	endtask

	// Write, then read the same byte at the very next edge; valid stands one cycle only
	task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
		wr(a, d);
		reg_rd = 1'b1;
		@(posedge clk_sys);
		#1 reg_rd = 1'b0;
		chk({7'h00, rd_valid_q}, 8'h01);
		chk(rd_data_q, mdl[a]);
		@(posedge clk_sys);
		#1 chk({7'h00, rd_valid_q}, 8'h00);
	endtask

	// Field outputs against the model image
	task automatic fields();
		chk({2'b00, boost_a_q}, mdl[8'h0f] & 8'h3f);
		chk({2'b00, boost_b_q}, mdl[8'h16] & 8'h3f);
		chk({4'h0, thresh_a_q}, mdl[8'h12] & 8'h0f);
		chk({4'h0, thresh_b_q}, mdl[8'h19] & 8'h0f);
		chk({1'b0, swing1_q}, mdl[8'h17] & 8'h7f);
		chk(swing2_q, mdl[8'h18]);
	endtask

	task automatic all_regs();
		foreach (addrs[i]) rd(addrs[i]);
		fields();
	endtask

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Watchdog, far beyond the few hundred cycles the sequence needs
	initial
	begin
		#(20000 * 5);
		error_cnt++;
		summarize();
	end

	// Main sequence
	initial
	begin
		model_reset();
		repeat (10) @(posedge clk_sys);
		#1 rst_b = 1'b1;
		all_regs();
		chk({6'h00, out0_mute_q, detect_en_q}, 8'h00);
		// Every documented boost code, alternating inputs, back to back
		foreach (codes[i])
		begin
			wr(8'h0f, codes[i]);
			wr_rd(8'h16, codes[8 - i]);
			fields();
		end
		// Random masked writes to random registers, then full readback
		repeat (40)
		begin
			seed = lfsr(seed);
			wr(addrs[seed[15:8] % 7], seed[7:0] & wmask[seed[15:8] % 7]);
		end
		wr(8'h15, 8'h00);
		all_regs();
		wr(8'h17, 8'h07);
		wr_rd(8'h18, 8'h01);
		// Unmapped places read zero and take no write
		wr(8'h13, 8'hff);
		rd(8'h13);
		rd(8'h00);
		all_regs();
		// Soft reset wins over a write in the same cycle
		@(posedge clk_sys);
		#1 soft_rst = 1'b1;
		reg_addr = 8'h19;
		reg_wdata = 8'h0f;
		reg_wr = 1'b1;
		@(posedge clk_sys);
		#1 soft_rst = 1'b0;
		reg_wr = 1'b0;
		model_reset();
		all_regs();
		// Manual mute levels
		wr(8'h15, 8'h10);
		repeat (2) @(posedge clk_sys);
		#1;
		chk({6'h00, out0_mute_q, detect_en_q}, 8'h02);
		wr(8'h15, 8'h00);
		repeat (2) @(posedge clk_sys);
		#1;
		chk({6'h00, out0_mute_q, detect_en_q}, 8'h00);
		// Automatic mute follows the selected detector, manual bit ignored
		wr(8'h15, 8'h30);
		for (int k = 0; k < 8; k++)
		begin
			@(posedge clk_sys);
			#1 sel_in_a = k[2];
			present_raw = k[1:0];
			repeat (8) @(posedge clk_sys);
			#1;
			chk({7'h00, out0_mute_q}, {7'h00, ~present_raw[k[2] ? 0 : 1]});
			chk({7'h00, detect_en_q}, 8'h01);
		end
		summarize();
	end
endmodule

`default_nettype wire
